/* hw/uvp_pkg.sv */
package uvp_pkg;
    // Geometry of the attached memory
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int WORDS = 1024;
    localparam logic [7:0] ERASED_WORD = 8'hFF;
    // Clock period in ns
    localparam int CLK_NS = 100;
    // Timer width, covers the longest pulse count
    localparam int TMR_W = 14;
    // Times as printed, in ns
    localparam int ACCESS_NS = 450;        // Address to output, worst grade
    localparam int DESELECT_FLOAT_NS = 120;
    localparam int SETUP_NS = 10000;       // Address, data, select setup
    localparam int HOLD_NS = 1000;         // Address and data hold
    localparam int SEL_HOLD_NS = 500;      // Select hold after pulse
    localparam int PROGRAM_TO_READ_NS = 10000;
    localparam int PULSE_MIN_NS = 100000;
    localparam int PULSE_MAX_NS = 1000000;
    localparam int TOTAL_PROGRAM_NS = 100000000;
    localparam int LOOPS_MIN = 100;
    localparam int LOOPS_MAX = 1000;
    // Least times round up to whole cycles
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC = (DESELECT_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEL_HOLD_CYC = (SEL_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC = (PROGRAM_TO_READ_NS + CLK_NS - 1) / CLK_NS;
    // Longest pulse rounds down, default pulse is the longest
    localparam int PULSE_CYC_DEF = PULSE_MAX_NS / CLK_NS;
    localparam int LOOPS_DEF = TOTAL_PROGRAM_NS / PULSE_MAX_NS;
    // Extra cycles of input synchroniser on read data
    localparam int SYNC_CYC = 2;
endpackage

/* hw/uvp_tmr_if.sv */
`timescale 1ns/1ps
// Delay timer hookup between controller and timer
interface uvp_tmr_if;
    logic load;                        // Start a new interval
    logic [uvp_pkg::TMR_W-1:0] cycles; // Interval length, at least one
    logic done;                        // Last cycle of the interval
    modport ctl (output load, output cycles, input done);
    modport tmr (input load, input cycles, output done);
endinterface

/* hw/uvp_timer.sv */
`timescale 1ns/1ps
module uvp_timer (
    input wire logic clk_i,
    input wire logic rst_b_i,
    uvp_tmr_if.tmr tmr
);
    logic [uvp_pkg::TMR_W-1:0] cnt_q; // Cycles left minus one

    // Load takes length minus one so a state lasts exactly that long
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= '0;
        end
        else if (tmr.load)
        begin
            cnt_q <= tmr.cycles - 1'b1;
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Done while the count rests at zero; load is built from done,
    // so done must not look back at load or the two would loop
    assign tmr.done = (cnt_q == '0);
endmodule

/* hw/uvp_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Elevated write level selects programming mode
// - Controller drives data lines while programming
// - Exactly one pulse per address per visit
// - N full loops over all 1024 addresses
// - Never two successive pulses on one address
// - Pulse 0.1 to 1.0 ms, N times >=100ms
// - Select changes after pulse, before address change
// - Drop write level before first read address
// - Wait 10 us after last pulse before reading
// - Drive program pin low between pulses
// - Unused addresses get all-ones data every loop
// - Rewrite earlier words with original data each loop
module uvp_ctrl #(
    parameter int PULSE_CYC = uvp_pkg::PULSE_CYC_DEF, // Pulse width cycles
    parameter int LOOPS = uvp_pkg::LOOPS_DEF          // Program loops N
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // User command side
    input wire logic rd_req_i,
    input wire logic [uvp_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [uvp_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic prog_start_i,
    output logic [uvp_pkg::ADDR_W-1:0] image_addr_o,
    input wire logic [uvp_pkg::DATA_W-1:0] image_data_i,
    input wire logic image_keep_i,
    output logic busy_o,
    output logic prog_done_o,
    // Memory pins
    output logic [uvp_pkg::ADDR_W-1:0] mem_addr_o,
    output logic chip_sel_b_o,
    output logic elevated_write_level_o,
    output logic program_pulse_high_level_o,
    output logic program_pulse_drive_o,
    input wire logic [uvp_pkg::DATA_W-1:0] data_lines_i,
    output logic [uvp_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_o
);
    typedef enum logic [3:0] {
        UVP_IDLE,
        UVP_RD_ACC,
        UVP_RD_FLOAT,
        UVP_PG_ENTER,
        UVP_PG_SETUP,
        UVP_PG_PULSE,
        UVP_PG_HOLD,
        UVP_PG_SELHOLD,
        UVP_PG_RECOVER
    } uvp_state_t;

    localparam logic [uvp_pkg::TMR_W-1:0] T_ACC =
        uvp_pkg::TMR_W'(uvp_pkg::ACCESS_CYC + uvp_pkg::SYNC_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_FLOAT =
        uvp_pkg::TMR_W'(uvp_pkg::FLOAT_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_SETUP =
        uvp_pkg::TMR_W'(uvp_pkg::SETUP_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_HOLD =
        uvp_pkg::TMR_W'(uvp_pkg::HOLD_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_SELHOLD =
        uvp_pkg::TMR_W'(uvp_pkg::SEL_HOLD_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_RECOVER =
        uvp_pkg::TMR_W'(uvp_pkg::RECOVER_CYC);
    localparam logic [uvp_pkg::TMR_W-1:0] T_PULSE =
        uvp_pkg::TMR_W'(PULSE_CYC);
    localparam logic [uvp_pkg::ADDR_W-1:0] LAST_ADDR =
        uvp_pkg::ADDR_W'(uvp_pkg::WORDS - 1);
    localparam logic [9:0] LAST_LOOP = 10'(LOOPS - 1);

    uvp_state_t state_q; // Sequencer state
    logic [uvp_pkg::ADDR_W-1:0] addr_q; // Address on the pins
    logic [9:0] loop_q; // Completed program loops
    logic [uvp_pkg::DATA_W-1:0] sync1_q; // Read data, first stage
    logic [uvp_pkg::DATA_W-1:0] sync2_q; // Read data, second stage
    logic sel_b_q; // Read select, active low
    logic write_lvl_q; // Elevated write level on
    logic pulse_q; // Program pin at high level
    logic [uvp_pkg::DATA_W-1:0] wdata_q; // Data driven in program mode
    logic data_oe_q; // Data line driver on
    logic [uvp_pkg::DATA_W-1:0] rd_data_q; // Captured read word
    logic rd_valid_q; // Read word ready pulse
    logic done_q; // Program sequence finished pulse
    logic busy_q; // Sequence in progress
    logic drive_q; // Program pin driver on
    logic [uvp_pkg::ADDR_W-1:0] img_addr_q; // Word asked of the image
    logic last_addr; // Current visit is the top word
    logic last_loop; // Current loop is the final one

    uvp_tmr_if tmr_if ();

    uvp_timer u_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .tmr(tmr_if)
    );

    assign last_addr = (addr_q == LAST_ADDR);
    assign last_loop = (loop_q == LAST_LOOP);

    // Timer loads on every state entry with that state's length
    always_comb
    begin
        tmr_if.load = 1'b0;
        tmr_if.cycles = T_FLOAT;
        case (state_q)
            UVP_IDLE:
            begin
                if (rd_req_i)
                begin
                    tmr_if.load = 1'b1;
                    tmr_if.cycles = T_ACC;
                end
                else if (prog_start_i)
                begin
                    tmr_if.load = 1'b1;
                    tmr_if.cycles = T_SETUP; // Select setup
                end
            end
            UVP_RD_ACC:
            begin
                tmr_if.load = tmr_if.done;
                tmr_if.cycles = T_FLOAT;
            end
            UVP_PG_ENTER:
            begin
                tmr_if.load = tmr_if.done;
                tmr_if.cycles = T_SETUP;
            end
            UVP_PG_SETUP:
            begin
                tmr_if.load = tmr_if.done;
                tmr_if.cycles = T_PULSE;
            end
            UVP_PG_PULSE:
            begin
                tmr_if.load = tmr_if.done;
                // Final pulse waits select hold instead of address hold
                if (last_addr && last_loop)
                begin
                    tmr_if.cycles = T_SELHOLD;
                end
                else
                begin
                    tmr_if.cycles = T_HOLD;
                end
            end
            UVP_PG_HOLD:
            begin
                tmr_if.load = tmr_if.done;
                tmr_if.cycles = T_SETUP;
            end
            UVP_PG_SELHOLD:
            begin
                tmr_if.load = tmr_if.done;
                tmr_if.cycles = T_RECOVER;
            end
            default:
            begin
                tmr_if.load = 1'b0;
                tmr_if.cycles = T_FLOAT;
            end
        endcase
    end

    // Sequencer; read wins over program when both are asked at once
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= UVP_IDLE;
        end
        else
        begin
            case (state_q)
                UVP_IDLE:
                begin
                    if (rd_req_i)
                    begin
                        state_q <= UVP_RD_ACC;
                    end
                    else if (prog_start_i)
                    begin
                        state_q <= UVP_PG_ENTER;
                    end
                end
                UVP_RD_ACC:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_RD_FLOAT;
                    end
                end
                UVP_RD_FLOAT:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_IDLE;
                    end
                end
                UVP_PG_ENTER:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_PG_SETUP;
                    end
                end
                UVP_PG_SETUP:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_PG_PULSE;
                    end
                end
                UVP_PG_PULSE:
                begin
                    if (tmr_if.done && last_addr && last_loop)
                    begin
                        state_q <= UVP_PG_SELHOLD;
                    end
                    else if (tmr_if.done)
                    begin
                        state_q <= UVP_PG_HOLD;
                    end
                end
                UVP_PG_HOLD:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_PG_SETUP; // Next address
                    end
                end
                UVP_PG_SELHOLD:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_PG_RECOVER;
                    end
                end
                UVP_PG_RECOVER:
                begin
                    if (tmr_if.done)
                    begin
                        state_q <= UVP_IDLE;
                    end
                end
                default:
                begin
                    state_q <= UVP_IDLE;
                end
            endcase
        end
    end

    // Address and loop counting; in a program run the address steps only after hold
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            addr_q <= '0;
            img_addr_q <= '0;
            loop_q <= '0;
        end
        else if (state_q == UVP_IDLE && rd_req_i)
        begin
            addr_q <= rd_addr_i;
            img_addr_q <= rd_addr_i;
        end
        else if (state_q == UVP_IDLE && prog_start_i)
        begin
            addr_q <= '0;
            img_addr_q <= '0;
            loop_q <= '0;
        end
        else if (state_q == UVP_PG_PULSE && tmr_if.done)
        begin
            // Image looks one word ahead so data moves with address
            img_addr_q <= addr_q + 1'b1;
        end
        else if (state_q == UVP_PG_HOLD && tmr_if.done)
        begin
            addr_q <= addr_q + 1'b1; // Wraps to zero
            if (last_addr)
            begin
                loop_q <= loop_q + 1'b1;
            end
        end
    end

    // Select and write level; read select is held high in program mode
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel_b_q <= 1'b1;
            write_lvl_q <= 1'b0;
        end
        else
        begin
            sel_b_q <= !(state_q == UVP_IDLE && rd_req_i) &&
                !(state_q == UVP_RD_ACC && !tmr_if.done);
            if (state_q == UVP_IDLE && !rd_req_i && prog_start_i)
            begin
                write_lvl_q <= 1'b1;
            end
            else if (state_q == UVP_PG_SELHOLD && tmr_if.done)
            begin
                write_lvl_q <= 1'b0; // Address still parked
            end
        end
    end

    // Program pin; the low level is always actively driven
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pulse_q <= 1'b0;
        end
        else
        begin
            pulse_q <= (state_q == UVP_PG_SETUP && tmr_if.done) ||
                (state_q == UVP_PG_PULSE && !tmr_if.done);
        end
    end

    // Program data; words not kept are written as all ones
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wdata_q <= uvp_pkg::ERASED_WORD;
            data_oe_q <= 1'b0;
        end
        else
        begin
            // Taken on the last cycle only, as the address moves or the first setup starts
            if ((state_q == UVP_PG_ENTER || state_q == UVP_PG_HOLD) &&
                tmr_if.done)
            begin
                // Image is the full wanted content
                wdata_q <= image_keep_i ? image_data_i :
                    uvp_pkg::ERASED_WORD;
            end
            // Drivers off with the write level, so no clash on read
            data_oe_q <= write_lvl_q &&
                !(state_q == UVP_PG_SELHOLD && tmr_if.done);
        end
    end

    // Read data passes two flops before it is captured
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            sync1_q <= data_lines_i;
            sync2_q <= sync1_q;
            rd_valid_q <= (state_q == UVP_RD_ACC) && tmr_if.done;
            if (state_q == UVP_RD_ACC && tmr_if.done)
            begin
                rd_data_q <= sync2_q;
            end
        end
    end

    // Status flags
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            done_q <= 1'b0;
            busy_q <= 1'b0;
            drive_q <= 1'b1;
        end
        else
        begin
            done_q <= (state_q == UVP_PG_RECOVER) && tmr_if.done;
            // Registered copy of the next state being other than idle
            if (state_q == UVP_IDLE)
            begin
                busy_q <= rd_req_i || prog_start_i;
            end
            else
            begin
                busy_q <= !(tmr_if.done && (state_q == UVP_RD_FLOAT ||
                    state_q == UVP_PG_RECOVER));
            end
            drive_q <= 1'b1; // Pin never floats
        end
    end

    assign busy_o = busy_q;
    assign image_addr_o = img_addr_q;
    assign mem_addr_o = addr_q;
    assign chip_sel_b_o = sel_b_q;
    assign elevated_write_level_o = write_lvl_q;
    assign program_pulse_high_level_o = pulse_q;
    assign program_pulse_drive_o = drive_q;
    assign data_lines_o = wdata_q;
    assign data_lines_oe_o = data_oe_q;
    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    assign prog_done_o = done_q;
endmodule

/* tb/uvp_ctrl_sva.sv */
`timescale 1ns/1ps
module uvp_chk #(
    parameter int PULSE_CYC = 3,
    parameter int LOOPS = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rd_valid_o,
    input wire logic [uvp_pkg::ADDR_W-1:0] mem_addr_o,
    input wire logic chip_sel_b_o,
    input wire logic elevated_write_level_o,
    input wire logic program_pulse_high_level_o,
    input wire logic program_pulse_drive_o,
    input wire logic [uvp_pkg::DATA_W-1:0] data_lines_o,
    input wire logic data_lines_oe_o
);
    // Counter restarts one edge late, so the floor is one below
    localparam int SETUP_MIN = uvp_pkg::SETUP_CYC - 1;
    wire pls = program_pulse_high_level_o; // Short alias
    wire lvl = elevated_write_level_o; // Short alias
    logic [9:0] addr_q; // Address at last edge
    logic [7:0] dat_q; // Data at last edge
    logic [7:0] stab_q; // Cycles address and data held
    logic [13:0] wid_q; // Cycles of current pulse
    logic [7:0] quiet_q; // Cycles since a pulse, saturating
    logic hit_q; // Current address already pulsed
    // Setup age: any move of address or data restarts it
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            addr_q <= '0;
            dat_q <= '0;
            stab_q <= '0;
        end
        else
        begin
            addr_q <= mem_addr_o;
            dat_q <= data_lines_o;
            if (mem_addr_o != addr_q || data_lines_o != dat_q)
                stab_q <= '0;
            else if (stab_q != 8'hFF)
                stab_q <= stab_q + 8'h01;
        end
    end
    // Pulse width, quiet time and per-visit pulse mark
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wid_q <= '0;
            quiet_q <= 8'hFF;
            hit_q <= 1'b0;
        end
        else
        begin
            wid_q <= pls ? wid_q + 14'h0001 : '0;
            if (pls)
                quiet_q <= '0;
            else if (quiet_q != 8'hFF)
                quiet_q <= quiet_q + 8'h01;
            // Cleared only by a new address, so a repeat shows
            if (pls)
                hit_q <= 1'b1;
            else if (mem_addr_o != addr_q)
                hit_q <= 1'b0;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Select low through the whole access window
    sequence sel_low7;
        !chip_sel_b_o [*7];
    endsequence
    // Address held after the pulse ends
    sequence addr_hold8;
        $stable(mem_addr_o) [*8];
    endsequence
    // Write level drops well after the pulse, address still
    sequence level_exit;
        (!$past(pls, 5) && $stable(mem_addr_o)) ##1 $stable(mem_addr_o);
    endsequence
    AST_PULSE_WIDTH: assert property ($fell(pls) |-> wid_q == PULSE_CYC)
        else $error("program pulse width wrong");
    AST_PULSE_MODE: assert property (pls |-> lvl && chip_sel_b_o
        && data_lines_oe_o) else $error("pulse outside write mode");
    AST_SETUP: assert property ($rose(pls) |-> stab_q >= SETUP_MIN)
        else $error("pulse setup too short");
    AST_HOLD: assert property ($fell(pls) |-> addr_hold8)
        else $error("address hold too short");
    AST_ONE_PULSE: assert property ($rose(pls) |-> !hit_q)
        else $error("second pulse on one address");
    AST_LEVEL_EXIT: assert property ($fell(lvl) |-> level_exit)
        else $error("write level dropped out of order");
    AST_READ_WINDOW: assert property ($fell(chip_sel_b_o) |-> sel_low7
        ##1 (chip_sel_b_o && rd_valid_o)) else $error("read window wrong");
    AST_FLOAT_GAP: assert property ($rose(chip_sel_b_o) |-> chip_sel_b_o [*2])
        else $error("reselect before float");
    AST_RECOVER: assert property ($fell(chip_sel_b_o) |-> !lvl
        && quiet_q >= uvp_pkg::RECOVER_CYC) else $error("read too early");
    AST_PIN_DRIVEN: assert property (program_pulse_drive_o)
        else $error("program pin undriven");
    AST_OE_MODE: assert property (data_lines_oe_o |-> lvl)
        else $error("data driven in read mode");
endmodule
bind uvp_ctrl uvp_chk #(
    .PULSE_CYC(PULSE_CYC),
    .LOOPS(LOOPS)
) i_uvp_chk (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .rd_valid_o(rd_valid_o),
    .mem_addr_o(mem_addr_o),
    .chip_sel_b_o(chip_sel_b_o),
    .elevated_write_level_o(elevated_write_level_o),
    .program_pulse_high_level_o(program_pulse_high_level_o),
    .program_pulse_drive_o(program_pulse_drive_o),
    .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o)
);

/* tb/uvp_eprom_model.sv */
`timescale 1ns/1ps
module uvp_eprom_model (
    input wire logic [uvp_pkg::ADDR_W-1:0] addr_i,
    input wire logic chip_sel_b_i,
    input wire logic write_level_i,
    input wire logic pulse_i,
    input wire logic [uvp_pkg::DATA_W-1:0] bus_i,
    output logic [uvp_pkg::DATA_W-1:0] data_o
);
    logic [7:0] mem [0:1023]; // One word per address
    wire [7:0] word; // Addressed word after access time
    wire drv; // Outputs enabled
    logic [7:0] last = 8'h00; // Last word driven
    // Erased part reads all ones
    initial
        for (int i = 0; i < uvp_pkg::WORDS; i++)
            mem[i] = uvp_pkg::ERASED_WORD;
    // A pulse can only clear bits, never set them
    always @(posedge pulse_i)
        if (write_level_i)
            mem[addr_i] = mem[addr_i] & bus_i;
    assign #(uvp_pkg::ACCESS_NS) word = mem[addr_i];
    // Enable and float both lag the select
    assign #(uvp_pkg::DESELECT_FLOAT_NS) drv = !chip_sel_b_i
        && !write_level_i;
    always @(word or drv)
        if (drv)
            last = word;
    // Floating pins show stale inverted data, not a lucky match
    assign data_o = drv ? word : ~last;
endmodule

/* tb/tb_uv_eprom_read_program_port.sv */
`timescale 1ns/1ps
module tb_uv_eprom_read_program_port;
    // Short pulse and one pass keep the run near 116k cycles
    localparam int PULSE = 3;
    localparam int LOOPS = 1;
    typedef struct {
        logic [9:0] a;
        logic [7:0] e;
    } uvp_row_t;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic [9:0] rd_addr_i = 10'h000;
    logic prog_start_i = 1'b0;
    logic blank = 1'b0; // Offer no data words at all
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic [9:0] image_addr_o;
    logic [9:0] mem_addr_o;
    logic busy_o;
    logic prog_done_o;
    logic chip_sel_b_o;
    logic elevated_write_level_o;
    logic program_pulse_high_level_o;
    logic program_pulse_drive_o;
    logic [7:0] data_lines_o;
    logic data_lines_oe_o;
    wire [7:0] dev_data; // Memory model output
    wire [7:0] data_lines_i; // Resolved data pins
    wire [7:0] image_data_i = image_addr_o[7:0] ^ 8'h5A;
    wire image_keep_i = !blank && image_addr_o[1:0] != 2'b11;
    int errors = 0;
    int tests_run = 0;
    int pulses = 0; // Pulses seen in a program run
    logic mon = 1'b0; // Pulse monitor enable
    // Read-back table; words with low bits 11 stay erased
    uvp_row_t rows [7] = '{
        '{10'h000, 8'h5A}, '{10'h001, 8'h5B}, '{10'h003, 8'hFF},
        '{10'h155, 8'h0F}, '{10'h200, 8'h5A}, '{10'h3FE, 8'hA4},
        '{10'h3FF, 8'hFF}};
    assign data_lines_i = data_lines_oe_o ? data_lines_o : dev_data;
    always #(uvp_pkg::CLK_NS / 2) clk_i = ~clk_i;
    uvp_ctrl #(
        .PULSE_CYC(PULSE),
        .LOOPS(LOOPS)
    ) i_uvp_ctrl (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .prog_start_i(prog_start_i), .image_addr_o(image_addr_o),
        .image_data_i(image_data_i), .image_keep_i(image_keep_i),
        .busy_o(busy_o), .prog_done_o(prog_done_o),
        .mem_addr_o(mem_addr_o), .chip_sel_b_o(chip_sel_b_o),
        .elevated_write_level_o(elevated_write_level_o),
        .program_pulse_high_level_o(program_pulse_high_level_o),
        .program_pulse_drive_o(program_pulse_drive_o),
        .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
        .data_lines_oe_o(data_lines_oe_o)
    );
    uvp_eprom_model i_uvp_eprom_model (
        .addr_i(mem_addr_o), .chip_sel_b_i(chip_sel_b_o),
        .write_level_i(elevated_write_level_o),
        .pulse_i(program_pulse_high_level_o),
        .bus_i(data_lines_i), .data_o(dev_data)
    );
    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp,
               input string what);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task wrap_up;
        $display("tests %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Idle pin state after a reset
    task pins_idle(input string t);
        check({chip_sel_b_o, elevated_write_level_o, data_lines_oe_o,
               busy_o, rd_valid_o, program_pulse_high_level_o,
               prog_done_o}, 16'h0040, t);
    endtask
    // Bounded wait for the controller to go idle
    task idle;
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 50)
        begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask
    task do_read(input logic [9:0] a, input logic [7:0] e);
        int n;
        idle();
        rd_req_i = 1'b1;
        rd_addr_i = a;
        @(posedge clk_i);
        #1 rd_req_i = 1'b0;
        n = 0;
        while (rd_valid_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        check(16'(n), 16'h0007, "read latency");
        check(rd_data_o, e, "read data");
    endtask
    task do_prog;
        int n;
        idle();
        prog_start_i = 1'b1;
        @(posedge clk_i);
        #1 prog_start_i = 1'b0;
        n = 0;
        while (prog_done_o !== 1'b1 && n < 130000)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        check(16'(n < 130000), 16'h0001, "program done");
    endtask
    // Every pulse in a run: ascending address, image word on the pins
    always @(posedge program_pulse_high_level_o)
        if (mon)
        begin
            check(mem_addr_o, 16'(pulses % 1024), "pulse address");
            check(data_lines_o, rows[0].e == 8'h5A && mem_addr_o[1:0]
                == 2'b11 ? 8'hFF : mem_addr_o[7:0] ^ 8'h5A,
                "pulse data");
            pulses++;
        end
    initial
    begin
        #14000000 errors++;
        $display("mismatch at %0t: watchdog", $time);
        wrap_up();
    end
    initial
    begin
        int v;
        int w;
        repeat (5) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        pins_idle("reset");
        do_read(10'h155, 8'hFF);
        mon = 1'b1;
        do_prog();
        mon = 1'b0;
        check(16'(pulses), 16'(1024 * LOOPS), "pulse count");
        $display("test program done");
        foreach (rows[i])
            do_read(rows[i].a, rows[i].e);
        $display("test read table done");
        // All-ones run cut short by reset must not restore bits
        idle();
        blank = 1'b1;
        prog_start_i = 1'b1;
        @(posedge clk_i);
        #1 prog_start_i = 1'b0;
        repeat (400) @(posedge clk_i);
        #1 rst_b_i = 1'b0;
        #1 pins_idle("abort");
        @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        blank = 1'b0;
        do_read(10'h000, 8'h5A);
        $display("test abort done");
        // Read and program together, both held while busy
        idle();
        rd_req_i = 1'b1;
        rd_addr_i = 10'h001;
        prog_start_i = 1'b1;
        v = 0;
        w = 0;
        repeat (9)
        begin
            @(posedge clk_i);
            #1 v += int'(rd_valid_o === 1'b1);
            w += int'(elevated_write_level_o !== 1'b0);
        end
        rd_req_i = 1'b0;
        prog_start_i = 1'b0;
        check(16'(v), 16'h0001, "one read while busy");
        check(16'(w), 16'h0000, "program refused");
        check(rd_data_o, 8'h5B, "read beats program");
        $display("test refusal done");
        wrap_up();
    end
endmodule
